// >>> dte_cfg.svh
// Register map, field positions, reset values and timing counts of the timer block.
// Assumes inclusion by bare name from every design file that needs the figures.
`ifndef DTE_CFG_SVH
`define DTE_CFG_SVH

// Number of timer/counter channels
`define DTE_NCH        2

// Register byte offsets on the Avalon-MM slave
`define DTE_OFS_CTRL   5'h00
`define DTE_OFS_CNT0   5'h04
`define DTE_OFS_CNT1   5'h08
`define DTE_OFS_STAT   5'h0c
`define DTE_OFS_MASK   5'h10

// Control field positions inside one channel nibble
`define DTE_CTL_RUN    0
`define DTE_CTL_SRC    1
`define DTE_CTL_GATE   2
`define DTE_CTL_STRIDE 4

// Reset values
`define DTE_RST_BYTE   8'h00
`define DTE_RST_DATA   32'h0000_0000

// Peripheral clock periods in one peripheral cycle
`define DTE_PER_CLKS   6

`endif

// >>> dte_pkg.sv
// Types shared by the timer block files.
// Assumes nothing of its surroundings.
package dte_pkg;
    // Count source of a channel
    typedef enum logic {
        DTE_SRC_TIMER = 1'b0,
        DTE_SRC_PIN   = 1'b1
    } dte_src_t;
    // Read answer sequencer
    typedef enum logic {
        DTE_BUS_IDLE = 1'b0,
        DTE_BUS_RDY  = 1'b1
    } dte_bus_t;
    // One 16-bit count and one count byte
    typedef logic [15:0] dte_cnt_t;
    typedef logic [7:0]  dte_byte_t;
endpackage

// >>> dte_presc.sv
// Peripheral cycle generator: one tick every DIV clocks.
// Assumes MCLK_I is the peripheral clock and runs free.
`timescale 1ns/100ps
`default_nettype none
`include "dte_cfg.svh"

module dte_presc #(
    parameter int DIV = `DTE_PER_CLKS
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    output logic      tick_o
);
    import dte_pkg::*;

    localparam int CW = $clog2(DIV);

    logic [CW-1:0] div_q;   // Position inside the peripheral cycle

    // Divider wraps at DIV-1 so the tick is exactly one clock wide
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q <= '0;
        end else if (tick_o) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    assign tick_o = (div_q == CW'(DIV - 1));

    AST_TICK_GAP: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE11]
        tick_o |=> !tick_o [*5] ##1 tick_o)
        else $error("Peripheral tick spacing is not six clocks");
endmodule
`default_nettype wire

// >>> dte_chan.sv
// One 16-bit timer/event counter channel built from two cascaded bytes.
// Assumes the pins are synchronous to clk_i and tick_i marks peripheral cycles.
`timescale 1ns/100ps
`default_nettype none
`include "dte_cfg.svh"

module dte_chan (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             tick_i,
    input  wire logic             run_i,
    input  wire dte_pkg::dte_src_t src_i,
    input  wire logic             gate_en_i,
    input  wire logic             gate_pin_i,
    input  wire logic             cnt_pin_i,
    input  wire logic             wr_lo_i,
    input  wire logic             wr_hi_i,
    input  wire dte_pkg::dte_byte_t wbyte_lo_i,
    input  wire dte_pkg::dte_byte_t wbyte_hi_i,
    output dte_pkg::dte_cnt_t     cnt_o,
    output logic                  inc_o,
    output logic                  ovf_o
);
    import dte_pkg::*;

    dte_byte_t lo_q;       // Low count byte
    dte_byte_t hi_q;       // High count byte
    logic      smp_q;      // Count pin level at the previous peripheral cycle
    logic      fall_w;     // High sample followed by low sample
    logic      go_w;       // Run bit, qualified by the gate pin when gating
    logic      carry_w;    // Low byte rolls over

    // Pin sampled once a peripheral cycle; reset low so no false edge
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            smp_q <= 1'b0;
        end else if (tick_i) begin
            smp_q <= cnt_pin_i; // [RULE12]
        end
    end

    assign fall_w  = tick_i & smp_q & ~cnt_pin_i; // [RULE12] [RULE3]
    assign go_w    = run_i & (~gate_en_i | gate_pin_i); // [RULE13] [RULE4]
    assign inc_o   = go_w & ((src_i == DTE_SRC_TIMER) ? tick_i : fall_w); // [RULE9] [RULE11]
    assign carry_w = inc_o & (lo_q == 8'hff);

    // Low byte: software preset wins, otherwise count; run rising alone keeps it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lo_q <= `DTE_RST_BYTE; // [RULE15]
        end else if (wr_lo_i) begin
            lo_q <= wbyte_lo_i;
        end else if (inc_o) begin
            lo_q <= lo_q + 8'h01; // [RULE4] [RULE6]
        end
    end

    // High byte advances on the low byte carry
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hi_q <= `DTE_RST_BYTE; // [RULE15]
        end else if (wr_hi_i) begin
            hi_q <= wbyte_hi_i;
        end else if (carry_w) begin
            hi_q <= hi_q + 8'h01; // [RULE5]
        end
    end

    // A preset in the same cycle cancels the overflow it would replace
    assign ovf_o = carry_w & (hi_q == 8'hff) & ~wr_lo_i & ~wr_hi_i; // [RULE5]
    assign cnt_o = {hi_q, lo_q};
endmodule
`default_nettype wire

// >>> dte_top.sv
// Dual 16-bit timer/event counter with an Avalon-MM register slave.
// Assumes one 250 MHz clock, pins synchronous to it, a well-behaved master.
// Function
// [RULE1] Two independent 16-bit timer/counter channels
// [RULE2] Timer counts interval, then requests interrupt
// [RULE3] Counter counts pin falls, then requests interrupt
// [RULE4] Run bit lets source increment low byte
// [RULE5] Byte carries cascade; high overflow sets flag
// [RULE6] Setting run keeps current count bytes
// [RULE7] Count bytes readable at any time
// [RULE8] Software stops channel before presetting counts
// [RULE9] Source bit picks prescaled clock or pin
// [RULE10] Software stops channel before changing source
// [RULE11] Timer advances once per six clocks
// [RULE12] Pin sampled per cycle; high-low counts
// [RULE13] Gate bit lets gate pin hold counting
// [RULE14] Servicing the interrupt clears overflow flag
// [RULE15] Reset clears counts, run and flag
//
// The Avalon-MM interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "dte_cfg.svh"

module dte_top (
    input  wire logic        MCLK_I,
    input  wire logic        RST_N_I,
    input  wire logic [4:0]  AVS_ADDRESS_I,
    input  wire logic        AVS_READ_I,
    input  wire logic        AVS_WRITE_I,
    input  wire logic [31:0] AVS_WRITEDATA_I,
    input  wire logic [3:0]  AVS_BYTEENABLE_I,
    output logic      [31:0] AVS_READDATA_O,
    output logic             AVS_WAITREQUEST_O,
    input  wire logic [1:0]  CNT_PIN_I,
    input  wire logic [1:0]  GATE_PIN_I,
    input  wire logic [1:0]  IRQ_ACK_I,
    output logic      [1:0]  OVF_O,
    output logic             IRQ_O
);
    import dte_pkg::*;

    localparam int NCH = `DTE_NCH;

    // Both channels share one prescaler, so their timer ticks stay in step.
    // The trade: two timers cannot be phase shifted against each other, but
    // the block saves a divider and reads of both counts line up.
    // Presets while running are deterministic here, yet software should not
    // lean on that; it stops a channel before touching its counts.

    // Register state
    logic     [NCH-1:0] run_q;     // Run control bits
    dte_src_t           src_q [NCH]; // Count source selects
    logic     [NCH-1:0] gate_q;    // Gate control bits
    logic     [NCH-1:0] ovf_q;     // Sticky overflow flags
    logic     [NCH-1:0] mask_q;    // Interrupt enables
    dte_bus_t           bus_q;     // Read answer sequencer
    logic     [31:0]    rdata_q;   // Registered read data

    // Channel wiring
    logic               tick_w;    // Peripheral cycle strobe
    dte_cnt_t           cnt_w [NCH]; // Live counts
    logic     [NCH-1:0] inc_w;     // Count strobes
    logic     [NCH-1:0] ovf_w;     // Overflow strobes
    logic     [NCH-1:0] wr_lo_w;   // Low byte preset strobes
    logic     [NCH-1:0] wr_hi_w;   // High byte preset strobes
    logic     [31:0]    rd_mux;    // Read data before the register

    // Word decode, ignoring the byte offset bits
    function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
        return a[4:2] == ofs[4:2];
    endfunction

    // Count register of a channel
    function automatic logic [4:0] cnt_ofs(input int ch);
        return (ch == 0) ? `DTE_OFS_CNT0 : `DTE_OFS_CNT1;
    endfunction

    // Bit position of a control field of a channel
    function automatic int fpos(input int ch, input int fld);
        return ch * `DTE_CTL_STRIDE + fld;
    endfunction

    // Shared peripheral cycle strobe for both channels
    dte_presc #(
        .DIV (`DTE_PER_CLKS)
    ) u_presc (
        .clk_i   (MCLK_I),
        .rst_n_i (RST_N_I),
        .tick_o  (tick_w)
    );

    // Count preset strobes; writes never wait
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            wr_lo_w[c] = AVS_WRITE_I && hit(AVS_ADDRESS_I, cnt_ofs(c)) && AVS_BYTEENABLE_I[0];
            wr_hi_w[c] = AVS_WRITE_I && hit(AVS_ADDRESS_I, cnt_ofs(c)) && AVS_BYTEENABLE_I[1];
        end
    end

    // Each channel owns its own control bits and counts
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        dte_chan u_chan ( // [RULE1]
            .clk_i      (MCLK_I),
            .rst_n_i    (RST_N_I),
            .tick_i     (tick_w),
            .run_i      (run_q[g]),
            .src_i      (src_q[g]),
            .gate_en_i  (gate_q[g]),
            .gate_pin_i (GATE_PIN_I[g]),
            .cnt_pin_i  (CNT_PIN_I[g]),
            .wr_lo_i    (wr_lo_w[g]),
            .wr_hi_i    (wr_hi_w[g]),
            .wbyte_lo_i (AVS_WRITEDATA_I[7:0]),
            .wbyte_hi_i (AVS_WRITEDATA_I[15:8]),
            .cnt_o      (cnt_w[g]),
            .inc_o      (inc_w[g]),
            .ovf_o      (ovf_w[g])
        );
    end

    // Control bits; changing source or gate while running is the user's risk
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            run_q  <= '0; // [RULE15]
            gate_q <= '0;
            for (int c = 0; c < NCH; c++) begin
                src_q[c] <= DTE_SRC_TIMER;
            end
        end else if (AVS_WRITE_I && hit(AVS_ADDRESS_I, `DTE_OFS_CTRL) && AVS_BYTEENABLE_I[0]) begin
            for (int c = 0; c < NCH; c++) begin
                run_q[c]  <= AVS_WRITEDATA_I[fpos(c, `DTE_CTL_RUN)];
                gate_q[c] <= AVS_WRITEDATA_I[fpos(c, `DTE_CTL_GATE)];
                src_q[c]  <= dte_src_t'(AVS_WRITEDATA_I[fpos(c, `DTE_CTL_SRC)]); // [RULE9]
            end
        end
    end

    // Interrupt enables
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mask_q <= '0;
        end else if (AVS_WRITE_I && hit(AVS_ADDRESS_I, `DTE_OFS_MASK) && AVS_BYTEENABLE_I[0]) begin
            mask_q <= AVS_WRITEDATA_I[NCH-1:0];
        end
    end

    // Overflow flags: a new overflow beats a same-cycle clear so none is lost
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ovf_q <= '0; // [RULE15]
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (ovf_w[c]) begin
                    ovf_q[c] <= 1'b1; // [RULE5] [RULE2] [RULE3]
                end else if (IRQ_ACK_I[c]) begin
                    ovf_q[c] <= 1'b0; // [RULE14]
                end else if (AVS_WRITE_I && hit(AVS_ADDRESS_I, `DTE_OFS_STAT)
                             && AVS_BYTEENABLE_I[0] && AVS_WRITEDATA_I[c]) begin
                    ovf_q[c] <= 1'b0;
                end
            end
        end
    end

    // Read multiplexer; unmapped words read as zero
    always_comb begin
        rd_mux = `DTE_RST_DATA;
        if (hit(AVS_ADDRESS_I, `DTE_OFS_CTRL)) begin
            for (int c = 0; c < NCH; c++) begin
                rd_mux[fpos(c, `DTE_CTL_RUN)]  = run_q[c];
                rd_mux[fpos(c, `DTE_CTL_SRC)]  = src_q[c];
                rd_mux[fpos(c, `DTE_CTL_GATE)] = gate_q[c];
            end
        end else if (hit(AVS_ADDRESS_I, `DTE_OFS_STAT)) begin
            rd_mux[NCH-1:0] = ovf_q;
        end else if (hit(AVS_ADDRESS_I, `DTE_OFS_MASK)) begin
            rd_mux[NCH-1:0] = mask_q;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (hit(AVS_ADDRESS_I, cnt_ofs(c))) begin
                    rd_mux[15:0] = cnt_w[c]; // [RULE7]
                end
            end
        end
    end

    // Read sequencer: one wait cycle so read data come from a flop
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            bus_q <= DTE_BUS_IDLE;
        end else begin
            unique case (bus_q)
                DTE_BUS_IDLE: begin
                    if (AVS_READ_I) begin
                        bus_q <= DTE_BUS_RDY;
                    end
                end
                DTE_BUS_RDY: begin
                    bus_q <= DTE_BUS_IDLE;
                end
            endcase
        end
    end

    // Read data captured live, even while counting
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rdata_q <= `DTE_RST_DATA;
        end else if (bus_q == DTE_BUS_IDLE && AVS_READ_I) begin
            rdata_q <= rd_mux; // [RULE7]
        end
    end

    assign AVS_READDATA_O    = rdata_q;
    assign AVS_WAITREQUEST_O = AVS_READ_I && (bus_q != DTE_BUS_RDY);
    assign OVF_O             = ovf_q;
    assign IRQ_O             = |(ovf_q & mask_q); // [RULE2] [RULE3]

    // Checks, all in the single clock domain
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RST_N_I);

    for (genvar g = 0; g < NCH; g++) begin : g_chk
        logic wr_any;  // Any preset of this channel
        logic clr_any; // Software clear of this channel's flag
        assign wr_any  = wr_lo_w[g] | wr_hi_w[g];
        assign clr_any = AVS_WRITE_I && hit(AVS_ADDRESS_I, `DTE_OFS_STAT)
                         && AVS_BYTEENABLE_I[0] && AVS_WRITEDATA_I[g];

        // A flag only falls through service or a software clear
        AST_OVF_STICKY: assert property ( // [RULE5]
            (ovf_q[g] && !IRQ_ACK_I[g] && !clr_any) |=> ovf_q[g])
            else $error("Overflow flag fell without a clear");

        // Software clear works like service, but loses to a new overflow
        AST_W1C_CLR: assert property ( // [RULE14]
            (clr_any && !ovf_w[g]) |=> !ovf_q[g])
            else $error("Write-one clear left the flag set");

        // A set flag with its enable on must reach the interrupt line
        AST_IRQ_LEVEL: assert property ( // [RULE2]
            (ovf_q[g] && mask_q[g]) |-> IRQ_O)
            else $error("Unmasked overflow did not raise the interrupt");

        // Preset of the low byte lands at the write edge
        AST_PRESET_LO: assert property ( // [RULE6]
            wr_lo_w[g] |=> cnt_w[g][7:0] == $past(AVS_WRITEDATA_I[7:0]))
            else $error("Low count byte preset did not land");

        // Preset of the high byte lands at the write edge
        AST_PRESET_HI: assert property ( // [RULE6]
            wr_hi_w[g] |=> cnt_w[g][15:8] == $past(AVS_WRITEDATA_I[15:8]))
            else $error("High count byte preset did not land");

        // Source select follows the control write
        AST_SRC_WR: assert property ( // [RULE9]
            (AVS_WRITE_I && hit(AVS_ADDRESS_I, `DTE_OFS_CTRL) && AVS_BYTEENABLE_I[0])
            |=> src_q[g] == dte_src_t'($past(AVS_WRITEDATA_I[fpos(g, `DTE_CTL_SRC)])))
            else $error("Count source did not follow the control write");

        AST_HOLD_STOPPED: assert property ( // [RULE4]
            (!run_q[g] && !wr_any) |=> $stable(cnt_w[g]))
            else $error("Stopped channel count changed");

        AST_RUN_KEEPS: assert property ( // [RULE6]
            ($rose(run_q[g]) && !$past(wr_any)) |-> cnt_w[g] == $past(cnt_w[g]))
            else $error("Starting a channel changed its count");

        AST_CARRY: assert property ( // [RULE5]
            (inc_w[g] && cnt_w[g][7:0] == 8'hff && !wr_any)
            |=> cnt_w[g][15:8] == 8'($past(cnt_w[g][15:8]) + 8'h01))
            else $error("Low byte carry did not reach high byte");

        AST_OVF_SET: assert property ( // [RULE5]
            (inc_w[g] && cnt_w[g] == 16'hffff && !wr_any)
            |=> ovf_q[g] && cnt_w[g] == 16'h0000)
            else $error("Count rollover did not set overflow flag");

        AST_TIMER_RATE: assert property ( // [RULE11]
            (inc_w[g] && src_q[g] == DTE_SRC_TIMER && $stable(src_q[g]))
            |=> !inc_w[g] [*5])
            else $error("Timer counted faster than once per six clocks");

        AST_PIN_FALL: assert property ( // [RULE12]
            (inc_w[g] && src_q[g] == DTE_SRC_PIN)
            |-> !CNT_PIN_I[g] && $past(CNT_PIN_I[g], 6))
            else $error("Counter advanced without a high then low sample");

        AST_SRC_TICK: assert property ( // [RULE9]
            inc_w[g] |-> tick_w)
            else $error("Count advanced off the peripheral cycle");

        AST_GATE: assert property ( // [RULE13]
            (gate_q[g] && !GATE_PIN_I[g]) |-> !inc_w[g])
            else $error("Gated channel counted with gate pin low");

        AST_ACK_CLR: assert property ( // [RULE14]
            (IRQ_ACK_I[g] && !ovf_w[g]) |=> !ovf_q[g])
            else $error("Serviced overflow flag stayed set");

        AST_READ_CNT: assert property ( // [RULE7]
            (AVS_READ_I && !AVS_WAITREQUEST_O && hit(AVS_ADDRESS_I, cnt_ofs(g)))
            |-> AVS_READDATA_O == {16'h0000, $past(cnt_w[g])})
            else $error("Count read did not return live count");

        AST_RESET: assert property ( // [RULE15]
            !$past(RST_N_I) |-> (!run_q[g] && !ovf_q[g] && cnt_w[g] == 16'h0000))
            else $error("Channel not cleared by reset");

        COV_OVERFLOW: cover property (ovf_w[g] && mask_q[g]);
        COV_PIN_COUNT: cover property (inc_w[g] && src_q[g] == DTE_SRC_PIN);
        COV_GATE_HOLD: cover property (run_q[g] && gate_q[g] && !GATE_PIN_I[g] && tick_w);
        COV_SW_CLEAR: cover property (clr_any && ovf_q[g]);
    end

    COV_READ: cover property (AVS_READ_I && !AVS_WAITREQUEST_O);

    // Writes never stall, so masters may skip wait logic on them
    AST_WR_NO_WAIT: assert property ( // [RULE7]
        (AVS_WRITE_I && !AVS_READ_I) |-> !AVS_WAITREQUEST_O)
        else $error("Write was stalled");

    // Every read sees exactly one wait cycle, then its data
    AST_RD_ONE_WAIT: assert property ( // [RULE7]
        (AVS_READ_I && bus_q == DTE_BUS_IDLE)
        |-> AVS_WAITREQUEST_O ##1 (!AVS_READ_I || !AVS_WAITREQUEST_O))
        else $error("Read did not answer after one wait cycle");
endmodule
`default_nettype wire

// >>> dte_pin_model.sv
// Behavioural far side of the timer block: count pins and gate pins.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none

module dte_pin_model (
    input  wire logic       clk_i,
    output logic      [1:0] cnt_pin_o,
    output logic      [1:0] gate_pin_o
);
    // Count pins idle high, so a first fall forms a high-low pair
    initial begin
        cnt_pin_o  = 2'h3;
        gate_pin_o = 2'h0;
    end

    // Gate level of one channel, changed on the edge
    task automatic set_gate(input int ch, input logic lvl);
        gate_pin_o[ch] <= lvl;
        @(posedge clk_i);
    endtask

    // Falls on one count pin; each level stands 8 clocks, over a peripheral cycle
    task automatic make_falls(input int ch, input int n);
        for (int i = 0; i < n; i++) begin
            cnt_pin_o[ch] <= 1'b0;
            repeat (8) @(posedge clk_i);
            cnt_pin_o[ch] <= 1'b1;
            repeat (8) @(posedge clk_i);
        end
    endtask
endmodule

`default_nettype wire

// >>> dual_timer_event_counter_test.sv
// Self-checking bench of the dual timer block over its Avalon-MM slave.
// Assumes dte_top, dte_cfg.svh and the pin model are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
`include "dte_cfg.svh"

module dual_timer_event_counter_test;
    logic        mclk;                 // 250 MHz clock
    logic        rst_n;                // Active low reset
    logic [4:0]  addr;                 // Bus address
    logic        rd;                   // Read request
    logic        wr;                   // Write request
    logic [31:0] wdata;                // Write data
    logic [3:0]  be;                   // Byte lanes, all on
    logic [31:0] rdata;                // Read data
    logic        wait_rq;              // Wait request
    logic [1:0]  cnt_pin;              // Count pins from the model
    logic [1:0]  gate_pin;             // Gate pins from the model
    logic [1:0]  ack;                  // Interrupt serviced pulses
    logic [1:0]  ovf;                  // Overflow flags
    logic        irq;                  // Interrupt line
    int          n_fail;               // Mismatches
    int          check_count;          // Comparisons
    logic [31:0] v;                    // Last read word
    logic [4:0]  ofs [6] = '{`DTE_OFS_CTRL, `DTE_OFS_CNT0, `DTE_OFS_CNT1,
                             `DTE_OFS_STAT, `DTE_OFS_MASK, 5'h14};

    dte_top dut_u (.MCLK_I(mclk), .RST_N_I(rst_n), .AVS_ADDRESS_I(addr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
        .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
        .AVS_WAITREQUEST_O(wait_rq), .CNT_PIN_I(cnt_pin), .GATE_PIN_I(gate_pin),
        .IRQ_ACK_I(ack), .OVF_O(ovf), .IRQ_O(irq));
    dte_pin_model pm_u (.clk_i(mclk), .cnt_pin_o(cnt_pin), .gate_pin_o(gate_pin));

    // Free running clock
    always #2 mclk = ~mclk;

    // One comparison; a mismatch is reported at once
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Write; waitrequest is read before the edge's updates land
    task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        do @(posedge mclk); while (wait_rq !== 1'b0);
        wr <= 1'b0;
        @(posedge mclk); // Spacing so the strobe is not set twice in one step
    endtask

    // Read; data are taken at the edge that sees waitrequest low
    task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
        addr <= a;
        rd   <= 1'b1;
        do @(posedge mclk); while (wait_rq !== 1'b0);
        d  = rdata;
        rd <= 1'b0;
        @(posedge mclk);
    endtask

    // Reset held for 16 clocks
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
    endtask

    // Every register and an unmapped word read zero, flags low
    task automatic test_reset();
        for (int i = 0; i < 6; i++) begin
            bus_rd(ofs[i], v);
            check(v, 32'h0);
        end
        check({30'h0, ovf}, 32'h0);
        check({31'h0, irq}, 32'h0);
        $display("test_reset done");
    endtask

    // Timer from a preset across the byte carry, exactly 60 clocks of run
    task automatic test_timer();
        bus_wr(`DTE_OFS_CTRL, 32'h0);
        bus_wr(`DTE_OFS_CNT0, 32'h12fe);
        bus_wr(`DTE_OFS_CNT1, 32'h0a5a);
        bus_wr(`DTE_OFS_CTRL, 32'h1); // Taken at edge A
        repeat (30) @(posedge mclk);
        bus_rd(`DTE_OFS_CNT0, v); // Captured at A+32: five or six ticks
        check({31'h0, v inside {32'h1303, 32'h1304}}, 32'h1);
        repeat (25) @(posedge mclk);
        bus_wr(`DTE_OFS_CTRL, 32'h0); // Taken at A+60: ten ticks
        bus_rd(`DTE_OFS_CNT0, v);
        check(v, 32'h1308);
        check(v, 32'h1308);
        check(v, 32'h1308);
        bus_rd(`DTE_OFS_CNT1, v);
        check(v, 32'h0a5a);
        check({30'h0, ovf}, 32'h0);
        $display("test_timer done");
    endtask

    // Overflow, mask, write-one-clear and service clear
    task automatic test_ovf();
        bus_wr(`DTE_OFS_CNT1, 32'hfffe);
        bus_wr(`DTE_OFS_CTRL, 32'h10); // Taken at edge A
        repeat (28) @(posedge mclk);
        bus_wr(`DTE_OFS_CTRL, 32'h0); // Taken at A+30: five ticks
        bus_rd(`DTE_OFS_CNT1, v);
        check(v, 32'h0003);
        check({30'h0, ovf}, 32'h2);
        check({31'h0, irq}, 32'h0); // Masked out
        bus_rd(`DTE_OFS_STAT, v);
        check(v, 32'h2);
        bus_wr(`DTE_OFS_MASK, 32'h2);
        check({31'h0, irq}, 32'h1);
        bus_wr(`DTE_OFS_STAT, 32'h1); // Other bit: flag stays
        check({30'h0, ovf}, 32'h2);
        bus_wr(`DTE_OFS_STAT, 32'h2);
        check({30'h0, ovf}, 32'h0);
        check({31'h0, irq}, 32'h0);
        bus_wr(`DTE_OFS_CNT1, 32'hffff);
        bus_wr(`DTE_OFS_CTRL, 32'h10);
        repeat (12) @(posedge mclk);
        bus_wr(`DTE_OFS_CTRL, 32'h0);
        check({31'h0, irq}, 32'h1);
        ack <= 2'h2;
        @(posedge mclk);
        ack <= 2'h0;
        @(posedge mclk);
        check({30'h0, ovf}, 32'h0);
        check({31'h0, irq}, 32'h0);
        $display("test_ovf done");
    endtask

    // Counter on pin falls, held by a low gate, rolling over
    task automatic test_pin();
        bus_wr(`DTE_OFS_CTRL, 32'h0);
        bus_wr(`DTE_OFS_CNT0, 32'hfffd);
        pm_u.set_gate(0, 1'b0);
        bus_wr(`DTE_OFS_CTRL, 32'h7);
        pm_u.make_falls(0, 3);
        bus_rd(`DTE_OFS_CNT0, v);
        check(v, 32'hfffd);
        pm_u.set_gate(0, 1'b1);
        pm_u.make_falls(0, 3); // Timer ticks must not count here
        bus_rd(`DTE_OFS_CNT0, v);
        check(v, 32'h0000);
        check(v, 32'h0000);
        check({30'h0, ovf}, 32'h1);
        bus_wr(`DTE_OFS_CTRL, 32'h0);
        ack <= 2'h1;
        @(posedge mclk);
        ack <= 2'h0;
        @(posedge mclk);
        check({30'h0, ovf}, 32'h0);
        $display("test_pin done");
    endtask

    // Counts, verdict and end of run
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Main sequence, ending with a reset in mid-run
    initial begin
        mclk = 1'b0; rst_n = 1'b0; addr = 5'h00; rd = 1'b0; wr = 1'b0;
        wdata = 32'h0; be = 4'hf; ack = 2'h0; n_fail = 0; check_count = 0;
        do_reset();
        test_reset();
        test_timer();
        test_ovf();
        test_pin();
        bus_wr(`DTE_OFS_CTRL, 32'h11);
        repeat (20) @(posedge mclk);
        do_reset();
        test_reset();
        summarize();
    end

    // Watchdog far beyond the some 350 clocks of the tests
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        summarize();
    end
endmodule

`default_nettype wire
